/* File: hdl/adcc_pkg.sv */
`default_nettype none
package adcc_pkg;
    localparam int RES_BITS = 10;
    localparam int NUM_CHAN = 8;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 8;

    // Register offsets.
    localparam logic [3:0] ADDR_MODE     = 4'h0;
    localparam logic [3:0] ADDR_START    = 4'h1;
    localparam logic [3:0] ADDR_RES_HI   = 4'h2;
    localparam logic [3:0] ADDR_RES_LO   = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_EN   = 4'h5;
    localparam logic [3:0] ADDR_IRQ_CLR  = 4'h6;

    // Field positions.
    localparam int MODE_CKS_BIT   = 7;
    localparam int START_FLAG_BIT = 7;
    localparam int IRQ_END_BIT    = 0;

    // Bits that always read as one.
    localparam logic [7:0] MODE_FIXED_ONES  = 8'h30;
    localparam logic [7:0] START_FIXED_ONES = 8'h7F;

    // Values after reset.
    localparam logic [3:0] CHAN_RST   = 4'h0;
    localparam logic       CKS_RST    = 1'b0;
    localparam logic [9:0] RESULT_RST = 10'h000;

    // Channel codes: the first selectable code and the one for input 1.
    localparam logic [3:0] CHAN_BASE = 4'h4;
    localparam logic [3:0] CHAN_AN1  = 4'h5;

    // Conversion timing in system clock cycles.
    localparam logic [2:0] DIV_SLOW         = 3'h4;
    localparam logic [2:0] DIV_FAST         = 3'h2;
    localparam logic [3:0] SAMPLE_TICKS     = 4'h4;
    localparam int         CONV_STATES_SLOW = 62;
    localparam int         CONV_STATES_FAST = 31;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b11,
        ST_DONE    = 2'b10
    } adcc_state_t;
endpackage
`default_nettype wire

/* File: hdl/adcc_sar_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface adcc_sar_if;
    logic       start;
    logic       abort;
    logic       fast;
    logic       cmp;
    logic       busy;
    logic       done;
    logic [9:0] result;
    logic [9:0] dac;
    logic       sample;

    modport ctrl (
        output start, abort, fast, cmp,
        input  busy, done, result, dac, sample
    );
    modport sar (
        input  start, abort, fast, cmp,
        output busy, done, result, dac, sample
    );
endinterface
`default_nettype wire

/* File: hdl/adcc_sar.sv */
`timescale 1ns/100ps
`default_nettype none
module adcc_sar (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Link to the control block
    adcc_sar_if.sar   sar
);
    adcc_pkg::adcc_state_t state_q, state_d;
    logic [2:0] div_q, div_d;
    logic [3:0] bit_q, bit_d;
    logic [9:0] code_q, code_d;
    logic       sample_q, sample_d;
    logic       tick;
    logic [2:0] div_last;
    logic [9:0] cur_mask;
    logic [9:0] next_mask;
    logic [9:0] trial_code;

    // A trial needs three edges to come back through the comparator
    // synchroniser, so a fast step lasts one cycle more than its divider.
    assign div_last  = sar.fast ? adcc_pkg::DIV_FAST
                                : adcc_pkg::DIV_SLOW - 3'h1;
    assign tick      = (div_q == div_last);
    assign cur_mask  = 10'h001 << bit_q;
    assign next_mask = cur_mask >> 1;
    // (RULE_08) Keep trial bit.
    assign trial_code = sar.cmp ? (code_q | next_mask)
                                : ((code_q & ~cur_mask) | next_mask);

    always_comb begin
        state_d  = state_q;
        div_d    = tick ? 3'h0 : div_q + 3'h1;
        bit_d    = bit_q;
        code_d   = code_q;
        sample_d = sample_q;
        case (state_q)
            adcc_pkg::ST_IDLE: begin
                div_d = 3'h0;
                if (sar.start) begin
                    state_d  = adcc_pkg::ST_SAMPLE;
                    sample_d = 1'b1;
                    bit_d    = 4'(adcc_pkg::RES_BITS - 1);
                    code_d   = 10'h200;
                end
            end
            adcc_pkg::ST_SAMPLE: begin
                // The first trial is compared during sampling, so the fast
                // mode still ends within its limit.
                if (tick) begin
                    state_d  = adcc_pkg::ST_CONVERT;
                    sample_d = 1'b0;
                    code_d   = trial_code;
                    bit_d    = bit_q - 4'h1;
                end
            end
            adcc_pkg::ST_CONVERT: begin
                if (tick) begin
                    code_d = trial_code;
                    if (bit_q == 4'h0) begin
                        state_d = adcc_pkg::ST_DONE;
                    end else begin
                        bit_d = bit_q - 4'h1;
                    end
                end
            end
            adcc_pkg::ST_DONE: begin
                state_d = adcc_pkg::ST_IDLE;
            end
            default: begin
                state_d = adcc_pkg::ST_IDLE;
            end
        endcase
        // (RULE_09) Abort drops back to idle.
        if (sar.abort && state_q != adcc_pkg::ST_IDLE) begin
            state_d  = adcc_pkg::ST_IDLE;
            sample_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q  <= adcc_pkg::ST_IDLE;
            div_q    <= 3'h0;
            bit_q    <= 4'h0;
            code_q   <= 10'h000;
            sample_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            div_q    <= div_d;
            bit_q    <= bit_d;
            code_q   <= code_d;
            sample_q <= sample_d;
        end
    end

    assign sar.busy   = (state_q != adcc_pkg::ST_IDLE);
    assign sar.done   = (state_q == adcc_pkg::ST_DONE);
    assign sar.result = code_q;
    assign sar.dac    = code_q;
    assign sar.sample = sample_q;
endmodule
`default_nettype wire

/* File: hdl/adcc_top.sv */
// Overview of operation
// (RULE_01) Channel code 0101 routes analog input 1 to the converter.
// (RULE_02) Writing 1 to the start flag starts a conversion on the selected channel.
// (RULE_03) At completion the flag sets, the result is stored, start clears, idle resumes.
// (RULE_04) Completion raises an interrupt request when the end interrupt is enabled.
// (RULE_05) After completion a new write of 1 starts a fresh conversion cycle.
// (RULE_06) Software reads the result only while the start flag reads 0.
// (RULE_07) Software waits 10 clock cycles after module standby before starting.
// (RULE_08) Results are unsigned 10-bit binary, zero low and all ones full scale.
// (RULE_09) Writing 0 to the start flag aborts a conversion in progress.
// (RULE_10) Software changes the channel only while the start flag is 0.
// (RULE_11) A conversion lasts at most 62 cycles at divide-4, 31 at divide-2.
// (RULE_12) The end flag stays set until cleared; the request follows flag and enable.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module adcc_top (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    // Analog front end
    input  wire logic       cmp_in,
    output var  logic [9:0] dac_code,
    output var  logic       sample_hold,
    output var  logic [7:0] chan_enable,
    // Interrupt
    output var  logic       irq
);
    adcc_sar_if sar_bus ();

    // Comparator synchroniser.
    logic cmp_s1_q, cmp_s1_d;
    logic cmp_s2_q, cmp_s2_d;

    // Mode register.
    logic [3:0] chan_q, chan_d;
    logic       cks_q, cks_d;

    // Start flag and result.
    logic       start_q, start_d;
    logic [9:0] result_q, result_d;
    logic       go;
    logic       stop;

    // Interrupt state.
    logic flag_q, flag_d;
    logic en_q, en_d;
    logic irq_q, irq_d;

    // Read data and channel enables.
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] mux_q, mux_d;
    logic [7:0] mux_sel;

    // Decoded write strobes.
    logic wr_mode;
    logic wr_start;
    logic wr_en;
    logic wr_clr;

    assign wr_mode  = reg_wr && (reg_addr == adcc_pkg::ADDR_MODE);
    assign wr_start = reg_wr && (reg_addr == adcc_pkg::ADDR_START);
    assign wr_en    = reg_wr && (reg_addr == adcc_pkg::ADDR_IRQ_EN);
    assign wr_clr   = reg_wr && (reg_addr == adcc_pkg::ADDR_IRQ_CLR);

    // The comparator is an asynchronous pin and is synchronised first.
    always_comb begin
        cmp_s1_d = cmp_in;
        cmp_s2_d = cmp_s1_q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            cmp_s1_q <= cmp_s1_d;
            cmp_s2_q <= cmp_s2_d;
        end
    end

    // Mode register.
    always_comb begin
        chan_d = chan_q;
        cks_d  = cks_q;
        // (RULE_10) Mode writes are ignored while a conversion runs.
        if (wr_mode && !start_q) begin
            chan_d = reg_wdata[3:0];
            cks_d  = reg_wdata[adcc_pkg::MODE_CKS_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_q <= adcc_pkg::CHAN_RST;
            cks_q  <= adcc_pkg::CKS_RST;
        end else begin
            chan_q <= chan_d;
            cks_q  <= cks_d;
        end
    end

    // Start flag, abort and result capture.
    always_comb begin
        start_d  = start_q;
        result_d = result_q;
        go       = 1'b0;
        stop     = 1'b0;
        if (sar_bus.done) begin
            // (RULE_03) Store result and clear start.
            start_d  = 1'b0;
            // (RULE_08) Result kept unsigned.
            result_d = sar_bus.result;
        end else if (wr_start) begin
            if (reg_wdata[adcc_pkg::START_FLAG_BIT]) begin
                // (RULE_02) Launch on write of one.
                // (RULE_05) Restart after completion.
                if (!start_q) begin
                    start_d = 1'b1;
                    go      = 1'b1;
                end
            end else if (start_q) begin
                // (RULE_09) Forced stop on zero.
                start_d = 1'b0;
                stop    = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start_q  <= 1'b0;
            result_q <= adcc_pkg::RESULT_RST;
        end else begin
            start_q  <= start_d;
            result_q <= result_d;
        end
    end

    // Interrupt flag, enable and request.
    always_comb begin
        flag_d = flag_q;
        en_d   = en_q;
        if (wr_clr && reg_wdata[adcc_pkg::IRQ_END_BIT]) begin
            flag_d = 1'b0;
        end
        // (RULE_03) Completion sets the end flag; a same-cycle clear loses.
        if (sar_bus.done) begin
            flag_d = 1'b1;
        end
        if (wr_en) begin
            en_d = reg_wdata[adcc_pkg::IRQ_END_BIT];
        end
        // (RULE_04) Request gated by enable.
        // (RULE_12) Level held by flag.
        irq_d = flag_d && en_d;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_q <= 1'b0;
            en_q   <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            flag_q <= flag_d;
            en_q   <= en_d;
            irq_q  <= irq_d;
        end
    end

    // One enable per analog input; codes outside the table select none.
    genvar g;
    generate
        for (g = 0; g < adcc_pkg::NUM_CHAN; g++) begin : g_chan
            // (RULE_01) Code 0101 picks input 1.
            assign mux_sel[g] = (chan_q == adcc_pkg::CHAN_BASE + 4'(g));
        end
    endgenerate

    always_comb begin
        mux_d = mux_sel;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mux_q <= 8'h00;
        end else begin
            mux_q <= mux_d;
        end
    end

    // Read data appear in the cycle after the strobe and only there.
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                adcc_pkg::ADDR_MODE: begin
                    rdata_d = adcc_pkg::MODE_FIXED_ONES
                            | {cks_q, 3'h0, chan_q};
                end
                adcc_pkg::ADDR_START: begin
                    rdata_d = adcc_pkg::START_FIXED_ONES
                            | {start_q, 7'h00};
                end
                adcc_pkg::ADDR_RES_HI: begin
                    rdata_d = result_q[9:2];
                end
                adcc_pkg::ADDR_RES_LO: begin
                    rdata_d = {result_q[1:0], 6'h00};
                end
                adcc_pkg::ADDR_IRQ_STAT: begin
                    rdata_d = {7'h00, flag_q};
                end
                adcc_pkg::ADDR_IRQ_EN: begin
                    rdata_d = {7'h00, en_q};
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Sequencer link.
    assign sar_bus.start = go;
    assign sar_bus.abort = stop;
    assign sar_bus.cmp   = cmp_s2_q;
    // (RULE_11) Clock select picks divide-2 or divide-4 stepping.
    assign sar_bus.fast  = cks_q;

    adcc_sar u_sar (
        .clk    (clk),
        .resetn (resetn),
        .sar    (sar_bus)
    );

    // Outputs.
    assign reg_rdata   = rdata_q;
    assign dac_code    = sar_bus.dac;
    assign sample_hold = sar_bus.sample;
    assign chan_enable = mux_q;
    assign irq         = irq_q;
endmodule
`default_nettype wire

/* File: verification/adcc_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module adcc_analog_model (
    // Converter side
    input  wire logic [9:0]  dac_code,
    input  wire logic [7:0]  chan_enable,
    // Analog levels, ten bits per input
    input  wire logic [79:0] levels,
    // Comparator
    output var  logic        cmp_in
);
    always_comb begin
        cmp_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (chan_enable[i] && levels[i*10 +: 10] >= dac_code) begin
                cmp_in = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/adcc_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module adcc_monitor (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Analog front end
    input wire logic       cmp_in,
    input wire logic [9:0] dac_code,
    input wire logic       sample_hold,
    input wire logic [7:0] chan_enable,
    // Interrupt
    input wire logic       irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic en_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_q <= 1'b0;
        end else if (reg_wr && reg_addr == adcc_pkg::ADDR_IRQ_EN) begin
            en_q <= reg_wdata[0];
        end
    end
    sequence s_launch;
        $rose(sample_hold) && en_q && !irq;
    endsequence
    // An abort or an enable change also ends the wait legally.
    sequence s_finish;
        irq || (reg_wr && (reg_addr == adcc_pkg::ADDR_START ||
                           reg_addr == adcc_pkg::ADDR_IRQ_EN));
    endsequence
    sequence s_abort;
        sample_hold && reg_wr && reg_addr == adcc_pkg::ADDR_START &&
            !reg_wdata[7];
    endsequence
    chk_start_launch: assert property ($rose(sample_hold) |->
        $past(reg_wr && reg_addr == adcc_pkg::ADDR_START && reg_wdata[7]))
        else $error("sampling began without a start write");
    chk_conv_bounded: assert property (s_launch |-> ##[1:62] s_finish)
        else $error("conversion did not finish in time");
    chk_irq_en_off: assert property (reg_wr &&
        reg_addr == adcc_pkg::ADDR_IRQ_EN && !reg_wdata[0] |=> !irq)
        else $error("request stayed up after enable cleared");
    chk_irq_needs_en: assert property (irq |-> en_q)
        else $error("request raised while disabled");
    chk_an1_route: assert property ($past(reg_rd &&
        reg_addr == adcc_pkg::ADDR_MODE) && reg_rdata[3:0] == 4'h5 |->
        chan_enable == 8'h02)
        else $error("code five does not select input one");
    chk_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_abort_stops: assert property (s_abort |=> !sample_hold)
        else $error("abort did not stop sampling");
    chk_abort_quiet: assert property (s_abort |=> (!$rose(irq))[*8])
        else $error("aborted conversion completed");
endmodule
bind adcc_top adcc_monitor adcc_monitor_i (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_in(cmp_in),
    .dac_code(dac_code), .sample_hold(sample_hold),
    .chan_enable(chan_enable), .irq(irq));
`default_nettype wire

/* File: verification/adcc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module adcc_top_tb;
    logic        clk, resetn, reg_wr, reg_rd, cmp_in, irq, sample_hold;
    logic        pend;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, chan_enable;
    logic [9:0]  dac_code, lvl;
    logic [79:0] levels;
    logic [7:0]  exp_q[$];
    logic [31:0] seed = 32'h6179;
    int          miscompares = 0;
    int          n_checks = 0;
    int          n;
    adcc_top adcc_top_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmp_in(cmp_in), .dac_code(dac_code),
        .sample_hold(sample_hold), .chan_enable(chan_enable), .irq(irq));
    adcc_analog_model adcc_analog_model_i (.dac_code(dac_code),
        .chan_enable(chan_enable), .levels(levels), .cmp_in(cmp_in));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    // Bounded wait for the request; the count is checked against the limit.
    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 200) begin
            @(posedge clk);
            #1;
            c++;
        end
        if (c >= 200) begin
            miscompares++;
            results();
        end
    endtask
    always @(posedge clk) pend <= reg_rd;
    always @(negedge clk) begin
        if (pend === 1'b1 && exp_q.size() > 0) begin
            chk({2'b00, reg_rdata}, {2'b00, exp_q.pop_front()});
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        levels = 80'h0;
        pend = 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
        rd(adcc_pkg::ADDR_MODE, 8'h30);
        rd(adcc_pkg::ADDR_START, 8'h7F);
        rd(adcc_pkg::ADDR_RES_HI, 8'h00);
        rd(adcc_pkg::ADDR_IRQ_STAT, 8'h00);
        rd(4'hF, 8'h00);
        for (int c = 0; c < 12; c++) begin
            wr(adcc_pkg::ADDR_MODE, 8'(c));
            @(posedge clk);
            #1 chk({2'b00, chan_enable}, 10'((c >= 4) ? (1 << (c - 4)) : 0));
        end
        wr(adcc_pkg::ADDR_IRQ_EN, 8'h01);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            lvl = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : seed[9:0];
            levels <= {{6{~lvl}}, lvl, ~lvl};
            wr(adcc_pkg::ADDR_MODE, {k[0], 7'h05});
            rd(adcc_pkg::ADDR_MODE, {k[0], 7'h35});
            wr(adcc_pkg::ADDR_START, 8'h80);
            wait_irq(n);
            chk(10'(n > (k[0] ? 31 : 62)), 10'h000);
            rd(adcc_pkg::ADDR_START, 8'h7F);
            rd(adcc_pkg::ADDR_IRQ_STAT, 8'h01);
            rd(adcc_pkg::ADDR_RES_HI, lvl[9:2]);
            rd(adcc_pkg::ADDR_RES_LO, {lvl[1:0], 6'h00});
            #1 chk(dac_code, lvl);
            #1 chk({9'h000, irq}, 10'h001);
            if (k == 2) begin
                wr(adcc_pkg::ADDR_IRQ_EN, 8'h00);
                #1 chk({9'h000, irq}, 10'h000);
                wr(adcc_pkg::ADDR_IRQ_EN, 8'h01);
                #1 chk({9'h000, irq}, 10'h001);
            end
            wr(adcc_pkg::ADDR_IRQ_CLR, 8'h01);
            #1 chk({9'h000, irq}, 10'h000);
        end
        wr(adcc_pkg::ADDR_MODE, 8'h05);
        wr(adcc_pkg::ADDR_START, 8'h80);
        wr(adcc_pkg::ADDR_START, 8'h00);
        repeat (80) @(posedge clk);
        #1 chk({9'h000, irq}, 10'h000);
        rd(adcc_pkg::ADDR_IRQ_STAT, 8'h00);
        rd(adcc_pkg::ADDR_START, 8'h7F);
        rd(adcc_pkg::ADDR_RES_HI, lvl[9:2]);
        repeat (3) @(posedge clk);
        results();
    end
endmodule
`default_nettype wire
